// file: wrc_pkg.sv
package wrc_pkg;

  // ==========================================================
  // Bus geometry and register offsets
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  OFS_CAUSE   = 8'h00;
  localparam logic [7:0]  OFS_OPTS    = 8'h01;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h02;
  localparam logic [7:0]  OFS_IRQ_MSK = 8'h03;

  // ==========================================================
  // Options register fields and value after reset
  localparam int          OPT_WDOG_EN = 7;
  localparam int          OPT_PERIOD  = 6;
  localparam int          OPT_STOP_OK = 5;
  localparam logic [7:0]  OPT_MASK    = 8'hE0;
  localparam logic [7:0]  OPTS_RST    = 8'hC0;

  // ==========================================================
  // Reset cause register layout
  typedef struct packed {
    logic       por;
    logic       pin;
    logic       wdog;
    logic       ilop;
    logic       lvd;
    logic [2:0] rsvd;
  } wrc_cause_s;

  localparam logic [7:0]  CAUSE_RST   = 8'h80;

  // ==========================================================
  // Interrupt status bits
  localparam int          IRQ_W       = 3;
  localparam int          IRQ_SERVICE = 0;
  localparam int          IRQ_REFUSED = 1;
  localparam int          IRQ_SEQ_END = 2;
  localparam logic [2:0]  IRQ_MSK_RST = 3'h0;

  // ==========================================================
  // Timing in bus cycles; bus rate is half the clock rate
  localparam int          BUS_DIV        = 2;
  localparam int          DRIVE_BUS_CYC  = 34;
  localparam int          SAMPLE_BUS_CYC = 38;
  localparam int          SEQ_CNT_W      = 6;
  localparam int          WDOG_LONG_EXP  = 18;
  localparam int          WDOG_SHORT_EXP = 13;
  localparam int          WDOG_CNT_W     = 19;

  // ==========================================================
  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DRIVE,
    ST_WAIT,
    ST_HOLD
  } wrc_state_e;

endpackage

// file: wrc_top.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module wrc_top #(
  parameter int WDOG_LONG_CYC  = 2 ** wrc_pkg::WDOG_LONG_EXP,
  parameter int WDOG_SHORT_CYC = 2 ** wrc_pkg::WDOG_SHORT_EXP
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        ARST_N,
  input  wire logic [wrc_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [wrc_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [wrc_pkg::DATA_W-1:0]  RDATA,
  input  wire logic                        BDM_ACTIVE,
  input  wire logic                        DBG_FORCE_RST,
  input  wire logic                        LVD_RST,
  input  wire logic                        STOP_EXEC,
  output logic                             STOP_ENTER,
  input  wire logic                        RST_PIN_I,
  output logic                             RST_PIN_O,
  output logic                             RST_PIN_OE,
  output logic                             SYS_RST,
  output logic                             CLKGEN_SELF,
  output logic                             IRQ
);

  // ==========================================================
  // Constants sized for the counters they meet
  localparam logic [wrc_pkg::WDOG_CNT_W-1:0] long_lim =
    wrc_pkg::WDOG_CNT_W'(WDOG_LONG_CYC - 1);
  localparam logic [wrc_pkg::WDOG_CNT_W-1:0] short_lim =
    wrc_pkg::WDOG_CNT_W'(WDOG_SHORT_CYC - 1);
  localparam logic [wrc_pkg::SEQ_CNT_W-1:0] drive_last =
    wrc_pkg::SEQ_CNT_W'(wrc_pkg::DRIVE_BUS_CYC - 1);
  localparam logic [wrc_pkg::SEQ_CNT_W-1:0] sample_last =
    wrc_pkg::SEQ_CNT_W'(wrc_pkg::SAMPLE_BUS_CYC - 1);
  localparam logic [wrc_pkg::SEQ_CNT_W-1:0] seq_zero =
    wrc_pkg::SEQ_CNT_W'(0);

  // ==========================================================
  // State
  wrc_pkg::wrc_state_e                  state_ff;
  wrc_pkg::wrc_state_e                  nxt_state;
  logic                                 div_ff;
  logic [wrc_pkg::SEQ_CNT_W-1:0]        seq_cnt_ff;
  logic [wrc_pkg::SEQ_CNT_W-1:0]        nxt_seq_cnt;
  logic [wrc_pkg::WDOG_CNT_W-1:0]       wdog_cnt_ff;
  logic [wrc_pkg::WDOG_CNT_W-1:0]       nxt_wdog_cnt;
  wrc_pkg::wrc_cause_s                  cause_ff;
  wrc_pkg::wrc_cause_s                  nxt_cause;
  logic [wrc_pkg::DATA_W-1:0]           opts_ff;
  logic [wrc_pkg::DATA_W-1:0]           nxt_opts;
  logic                                 lock_ff;
  logic                                 nxt_lock;
  logic [wrc_pkg::IRQ_W-1:0]            irq_st_ff;
  logic [wrc_pkg::IRQ_W-1:0]            nxt_irq_st;
  logic [wrc_pkg::IRQ_W-1:0]            irq_msk_ff;
  logic [wrc_pkg::DATA_W-1:0]           rdata_ff;
  logic [wrc_pkg::DATA_W-1:0]           nxt_rdata;
  logic                                 self_ff;
  logic                                 stop_ff;

  // ==========================================================
  // Register decode
  wire sel_cause   = (ADDR == wrc_pkg::OFS_CAUSE);
  wire sel_opts    = (ADDR == wrc_pkg::OFS_OPTS);
  wire sel_irq_st  = (ADDR == wrc_pkg::OFS_IRQ_ST);
  wire sel_irq_msk = (ADDR == wrc_pkg::OFS_IRQ_MSK);
  wire in_run      = (state_ff == wrc_pkg::ST_RUN);

  // Service is a write strobe to the cause offset; the data bus is never looked at
  wire service     = WR & sel_cause;
  wire opts_wr     = WR & sel_opts & in_run;
  wire opts_take   = opts_wr & ~lock_ff;
  wire opts_refuse = opts_wr & lock_ff;
  wire irq_st_rd   = RD & sel_irq_st;

  wire wdog_en     = opts_ff[wrc_pkg::OPT_WDOG_EN];
  wire period_long = opts_ff[wrc_pkg::OPT_PERIOD];
  wire stop_ok     = opts_ff[wrc_pkg::OPT_STOP_OK];

  // ==========================================================
  // Bus-rate enable: one pulse every second clock
  wire bus_en = div_ff;

  // ==========================================================
  // Watchdog
  // Suspended in background debug so a halted core is not reset
  wire wdog_run = in_run & wdog_en & ~BDM_ACTIVE;
  wire [wrc_pkg::WDOG_CNT_W-1:0] wdog_lim =
    period_long ? long_lim : short_lim;
  wire wdog_to = wdog_run & bus_en & (wdog_cnt_ff == wdog_lim) & ~service;

  always_comb begin
    nxt_wdog_cnt = wdog_cnt_ff;
    if (!in_run || service) begin
      nxt_wdog_cnt = '0;
    end else if (wdog_run && bus_en) begin
      nxt_wdog_cnt = wdog_cnt_ff + 1'b1;
    end
  end

  // ==========================================================
  // Reset sources
  wire ilop_rst = in_run & STOP_EXEC & ~stop_ok;
  wire pin_rst  = in_run & ~RST_PIN_I;
  wire lvd_rst  = in_run & LVD_RST;
  wire dbg_rst  = in_run & DBG_FORCE_RST;
  wire any_rst  = wdog_to | ilop_rst | pin_rst | lvd_rst | dbg_rst;
  wire stop_go  = in_run & STOP_EXEC & stop_ok;

  wire seq_last_drive  = bus_en & (seq_cnt_ff == drive_last);
  wire seq_last_sample = bus_en & (seq_cnt_ff == sample_last);

  // ==========================================================
  // Reset sequencer
  always_comb begin
    nxt_state   = state_ff;
    nxt_seq_cnt = seq_cnt_ff;
    nxt_cause   = cause_ff;
    unique case (state_ff)
      wrc_pkg::ST_RUN: begin
        if (any_rst) begin
          nxt_state   = wrc_pkg::ST_DRIVE;
          nxt_seq_cnt = seq_zero;
          // Debug-forced reset clears all flags and sets none
          nxt_cause   = '0;
          nxt_cause.pin  = pin_rst;
          nxt_cause.wdog = wdog_to;
          nxt_cause.ilop = ilop_rst;
          nxt_cause.lvd  = lvd_rst;
        end
      end
      wrc_pkg::ST_DRIVE: begin
        if (bus_en) begin
          nxt_seq_cnt = seq_cnt_ff + 1'b1;
        end
        if (seq_last_drive) begin
          nxt_state   = wrc_pkg::ST_WAIT;
          nxt_seq_cnt = seq_zero;
        end
      end
      wrc_pkg::ST_WAIT: begin
        if (bus_en) begin
          nxt_seq_cnt = seq_cnt_ff + 1'b1;
        end
        if (seq_last_sample) begin
          nxt_seq_cnt = seq_zero;
          if (!RST_PIN_I) begin
            // Pin still held low from outside: the pin owns this reset
            nxt_cause = '0;
            nxt_cause.pin = 1'b1;
            nxt_state = wrc_pkg::ST_HOLD;
          end else begin
            nxt_state = wrc_pkg::ST_RUN;
          end
        end
      end
      wrc_pkg::ST_HOLD: begin
        if (RST_PIN_I) begin
          nxt_state = wrc_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff    <= wrc_pkg::ST_DRIVE;
      seq_cnt_ff  <= '0;
      div_ff      <= 1'b0;
      wdog_cnt_ff <= '0;
      cause_ff    <= wrc_pkg::CAUSE_RST;
    end else begin
      state_ff    <= nxt_state;
      seq_cnt_ff  <= nxt_seq_cnt;
      div_ff      <= ~div_ff;
      wdog_cnt_ff <= nxt_wdog_cnt;
      cause_ff    <= nxt_cause;
    end
  end

  // ==========================================================
  // Options register, write-once until the next reset
  always_comb begin
    nxt_opts = opts_ff;
    nxt_lock = lock_ff;
    if (!in_run) begin
      nxt_opts = wrc_pkg::OPTS_RST;
      nxt_lock = 1'b0;
    end else if (opts_take) begin
      nxt_opts = WDATA & wrc_pkg::OPT_MASK;
      nxt_lock = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      opts_ff <= wrc_pkg::OPTS_RST;
      lock_ff <= 1'b0;
    end else begin
      opts_ff <= nxt_opts;
      lock_ff <= nxt_lock;
    end
  end

  // ==========================================================
  // Interrupt status: sticky, cleared by reading, set beats clear
  wire [wrc_pkg::IRQ_W-1:0] irq_ev;
  assign irq_ev[wrc_pkg::IRQ_SERVICE] = service & in_run;
  assign irq_ev[wrc_pkg::IRQ_REFUSED] = opts_refuse;
  assign irq_ev[wrc_pkg::IRQ_SEQ_END] = (state_ff != wrc_pkg::ST_RUN) &
                                        (nxt_state == wrc_pkg::ST_RUN);

  always_comb begin
    nxt_irq_st = irq_st_ff;
    if (irq_st_rd) begin
      nxt_irq_st = '0;
    end
    nxt_irq_st = nxt_irq_st | irq_ev;
  end

  // Status and mask survive internal resets so software can see why it woke
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_st_ff  <= '0;
      irq_msk_ff <= wrc_pkg::IRQ_MSK_RST;
    end else begin
      irq_st_ff <= nxt_irq_st;
      if (WR && sel_irq_msk) begin
        irq_msk_ff <= WDATA[wrc_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  wire [wrc_pkg::DATA_W-1:0] irq_st_rd_val  = {5'h00, irq_st_ff};
  wire [wrc_pkg::DATA_W-1:0] irq_msk_rd_val = {5'h00, irq_msk_ff};
  wire [wrc_pkg::DATA_W-1:0] rd_mux =
    sel_cause   ? cause_ff       :
    sel_opts    ? opts_ff        :
    sel_irq_st  ? irq_st_rd_val  :
    sel_irq_msk ? irq_msk_rd_val : 8'h00;

  assign nxt_rdata = RD ? rd_mux : 8'h00;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Clock fallback request and stop grant
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      self_ff <= 1'b1;
      stop_ff <= 1'b0;
    end else begin
      self_ff <= in_run & any_rst;
      stop_ff <= stop_go;
    end
  end

  // ==========================================================
  // Outputs
  // Pin is open drain: driven low only, the pullup does the rest
  assign RST_PIN_O   = 1'b0;
  assign RST_PIN_OE  = (state_ff == wrc_pkg::ST_DRIVE);
  assign SYS_RST     = ~in_run;
  assign CLKGEN_SELF = self_ff;
  assign STOP_ENTER  = stop_ff;
  assign RDATA       = rdata_ff;
  assign IRQ         = |(irq_st_ff & irq_msk_ff);

endmodule

// file: wrc_pin_model.sv
`timescale 1ns/10ps
// ==========================================================
// Board side of the reset pin
module wrc_pin_model (
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic ext_hold,
  output logic      pin_level
);
  // Pullup wins unless the block pulls low or a board source holds it low
  assign pin_level = ((drive_en && !drive_val) || ext_hold) ? 1'b0 : 1'b1;
endmodule

// file: wrc_top_properties.sv
`timescale 1ns/10ps
module wrc_top_properties (
  input wire logic       CLK_SYS,
  input wire logic       ARST_N,
  input wire logic       LVD_RST,
  input wire logic       DBG_FORCE_RST,
  input wire logic       STOP_EXEC,
  input wire logic       STOP_ENTER,
  input wire logic       RST_PIN_I,
  input wire logic       RST_PIN_O,
  input wire logic       RST_PIN_OE,
  input wire logic       SYS_RST,
  input wire logic       CLKGEN_SELF
);
  // ==========================================================
  // Length of the current pin drive, in clocks
  logic [7:0] oe_cnt_ff;
  logic [7:0] nxt_oe_cnt;

  assign nxt_oe_cnt = RST_PIN_OE ? oe_cnt_ff + 8'h01 : 8'h00;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      oe_cnt_ff <= 8'h00;
    else
      oe_cnt_ff <= nxt_oe_cnt;
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  // ==========================================================
  // Reset pin and sequence
  a_pin_open_drain: assert property (RST_PIN_O == 1'b0)
    else $error("reset pin output value not low");
  a_oe_in_reset: assert property (RST_PIN_OE |-> SYS_RST)
    else $error("pin driven outside reset");
  // 34 bus cycles are 68 clocks; the bus enable phase allows a small slack
  a_drive_length: assert property ($fell(RST_PIN_OE) |-> oe_cnt_ff inside {[8'h41:8'h47]})
    else $error("pin drive length wrong");
  a_sample_delay: assert property ($fell(RST_PIN_OE) && RST_PIN_I |-> ##72 SYS_RST ##[2:6] !SYS_RST)
    else $error("pin sample moment wrong");
  a_entry_drives: assert property ((LVD_RST || DBG_FORCE_RST || !RST_PIN_I) && !SYS_RST
                                   |=> SYS_RST && RST_PIN_OE)
    else $error("reset source did not start drive");
  a_clkgen_entry: assert property ($rose(SYS_RST) |-> CLKGEN_SELF)
    else $error("no self clock switch on reset");
  a_clkgen_pulse: assert property (CLKGEN_SELF |=> !CLKGEN_SELF)
    else $error("self clock request too long");

  // ==========================================================
  // Stop handling
  a_stop_cause: assert property (STOP_ENTER |-> $past(STOP_EXEC) && !$past(SYS_RST))
    else $error("stop entered without request");
  a_stop_refused: assert property (STOP_EXEC && !SYS_RST |=> STOP_ENTER != SYS_RST)
    else $error("stop neither entered nor refused");
endmodule

bind wrc_top wrc_top_properties u_wrc_top_properties (
  .CLK_SYS      (CLK_SYS),
  .ARST_N       (ARST_N),
  .LVD_RST      (LVD_RST),
  .DBG_FORCE_RST(DBG_FORCE_RST),
  .STOP_EXEC    (STOP_EXEC),
  .STOP_ENTER   (STOP_ENTER),
  .RST_PIN_I    (RST_PIN_I),
  .RST_PIN_O    (RST_PIN_O),
  .RST_PIN_OE   (RST_PIN_OE),
  .SYS_RST      (SYS_RST),
  .CLKGEN_SELF  (CLKGEN_SELF)
);

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic       clk_sys, arst_n, wr, rd, bdm, dbg, lvd, stop, hold, rd_taken;
  logic       stop_enter, pin_i, pin_o, pin_oe, sys_rst, clkgen, irq;
  logic [7:0] addr, wdata, rdata;
  logic [7:0] exp_q[$];
  logic [7:0] causes[3] = '{8'h08, 8'h00, 8'h10};
  int         bad_count, num_checks, cyc;

  // Small limits: long timeout 64 bus cycles, short 16
  wrc_top #(.WDOG_LONG_CYC(64), .WDOG_SHORT_CYC(16)) u_wrc_top (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BDM_ACTIVE(bdm), .DBG_FORCE_RST(dbg), .LVD_RST(lvd), .STOP_EXEC(stop),
    .STOP_ENTER(stop_enter), .RST_PIN_I(pin_i), .RST_PIN_O(pin_o), .RST_PIN_OE(pin_oe),
    .SYS_RST(sys_rst), .CLKGEN_SELF(clkgen), .IRQ(irq));
  wrc_pin_model u_wrc_pin_model (
    .drive_en(pin_oe), .drive_val(pin_o), .ext_hold(hold), .pin_level(pin_i));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Reporting
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      stop_test;
    end
  end

  // ==========================================================
  // Register bus; read data stands only in the cycle after the strobe
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  always @(posedge clk_sys) rd_taken <= rd;
  always @(negedge clk_sys) if (rd_taken) chk("rdata", rdata, exp_q.pop_front());

  // ==========================================================
  // Reset sequence helpers
  task automatic settle;
    int n;
    n = 0;
    while (sys_rst !== 1'b0 && n < 600) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("seq_end", 8'(n < 600), 8'h01);
  endtask

  // Clocks from now until reset starts must fall in lo..hi
  task automatic expire(int lo, int hi, logic [7:0] cause);
    int n;
    n = 0;
    while (sys_rst !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("entry_time", 8'(n >= lo && n <= hi), 8'h01);
    settle;
    rd_reg(8'h00, cause);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h20ED32F3));
    {arst_n, wr, rd, bdm, dbg, lvd, stop, hold} = 8'h00;
    {addr, wdata} = 16'h0000;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    settle;
    rd_reg(8'h00, 8'h80);
    rd_reg(8'h01, 8'hC0);
    rd_reg(8'($urandom_range(255, 4)), 8'h00);
    rd_reg(8'h03, 8'h00);
    rd_reg(8'h02, 8'h04);
    wr_reg(8'h03, 8'h01);
    wr_reg(8'h00, 8'($urandom));
    repeat (2) @(negedge clk_sys);
    chk("irq", irq, 8'h01);
    rd_reg(8'h02, 8'h01);
    rd_reg(8'h00, 8'h80);
    repeat (2) @(negedge clk_sys);
    chk("irq", irq, 8'h00);
    repeat (3) begin
      repeat (100) @(posedge clk_sys);
      // Service comes from the main flow, never from an interrupt path
      wr_reg(8'h00, 8'($urandom));
    end
    chk("sys_rst", sys_rst, 8'h00);
    expire(124, 134, 8'h20);
    rd_reg(8'h01, 8'hC0);
    @(posedge clk_sys);
    bdm <= 1'b1;
    repeat (300) @(posedge clk_sys);
    chk("sys_rst", sys_rst, 8'h00);
    bdm <= 1'b0;
    wr_reg(8'h01, 8'hA0);
    wr_reg(8'h00, 8'($urandom));
    expire(28, 38, 8'h20);
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h01, 8'hC0);
    rd_reg(8'h01, 8'h00);
    // Service, refused options write and sequence end all pending
    rd_reg(8'h02, 8'h07);
    repeat (600) @(posedge clk_sys);
    chk("sys_rst", sys_rst, 8'h00);
    // Low voltage, debug-forced and refused stop, one after another
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      lvd <= (k == 0);
      dbg <= (k == 1);
      stop <= (k == 2);
      @(posedge clk_sys);
      {lvd, dbg, stop} <= 3'h0;
      expire(0, 3, causes[k]);
    end
    wr_reg(8'h01, 8'h20);
    @(posedge clk_sys);
    stop <= 1'b1;
    @(posedge clk_sys);
    stop <= 1'b0;
    @(negedge clk_sys);
    chk("stop_enter", stop_enter, 8'h01);
    @(posedge clk_sys);
    hold <= 1'b1;
    repeat (200) @(posedge clk_sys);
    chk("sys_rst", sys_rst, 8'h01);
    hold <= 1'b0;
    settle;
    chk("pin", pin_i, 8'h01);
    rd_reg(8'h00, 8'h40);
    // Asynchronous reset in mid-run must restore defaults and the por flag
    wr_reg(8'h01, 8'h00);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    settle;
    rd_reg(8'h00, 8'h80);
    rd_reg(8'h01, 8'hC0);
    repeat (4) @(posedge clk_sys);
    stop_test;
  end
endmodule
